// ===== core/arith_unit_pkg.sv
/*
 * shared definitions for the signed arithmetic unit bank: widths, unit count,
 * operation codes, reset values and the packed carriers for operands and status.
 * assumes nothing of its surroundings beyond a single system clock domain.
 */
package arith_unit_pkg;

   // data path and bank size
   localparam int DATA_W = 32;
   localparam int PROD_W = 2 * DATA_W;
   localparam int UNIT_COUNT = 32;

   // signed constants for the range and zero checks: minimum, minus one and zero
   localparam logic signed [DATA_W-1:0] VALUE_MIN = 32'h8000_0000;
   localparam logic signed [DATA_W-1:0] VALUE_MINUS_ONE = 32'hFFFF_FFFF;
   localparam logic signed [DATA_W-1:0] VALUE_ZERO = 32'h0000_0000;

   // operation selection
   typedef enum logic [1:0] {
      OP_ADD,
      OP_SUB,
      OP_MUL,
      OP_DIV
   } arith_op_t;

   // reset values
   localparam arith_op_t MODE_RESET = OP_ADD;
   localparam logic signed [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;
   localparam logic OVERFLOW_RESET = 1'b0;
   localparam logic ZERO_RESET = 1'b1;

   // both operands of one unit
   typedef struct packed {
      logic signed [DATA_W-1:0] first;
      logic signed [DATA_W-1:0] second;
   } operand_pair_t;

   // per-unit answer: held result plus both flags
   typedef struct packed {
      logic signed [DATA_W-1:0] result;
      logic overflow;
      logic zero;
   } unit_status_t;

   localparam unit_status_t STATUS_RESET = '{result: RESULT_RESET, overflow: OVERFLOW_RESET, zero: ZERO_RESET};

endpackage

// ===== core/arithmetic_unit.sv
/*
 * bank of independent signed 32-bit arithmetic units (add, subtract,
 * multiply, truncating divide), each with its own mode, operands, held
 * result and overflow/zero flags, evaluated on every clock edge.
 * assumes operands, mode writes and the synchronous clear come from logic
 * on clk_sys_i, so no input is synchronised.
 * limitations: the overflow flag shows only the latest evaluation and is not
 * sticky, and a unit keeps presenting its last good result for as long as its
 * operands stay out of range.
 * the divider is one combinational stage: it costs area and a long path, but
 * every mode answers in the same single cycle, so callers need no busy signal.
 * mode_o shows the mode that the next edge will use; a write lands one edge
 * after its strobe.
 */
`timescale 1ns/1ps

module arithmetic_unit
   import arith_unit_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic sync_clear_i,
   input wire logic [UNIT_COUNT-1:0] mode_we_i,
   input wire arith_op_t mode_i [UNIT_COUNT],
   input wire operand_pair_t operand_i [UNIT_COUNT],
   output logic [DATA_W-1:0] result_output_o [UNIT_COUNT],
   output logic [UNIT_COUNT-1:0] overflow_flag_o,
   output logic [UNIT_COUNT-1:0] zero_flag_o,
   output arith_op_t mode_o [UNIT_COUNT]
);

   // one fully separate data path per unit; nothing is shared, so units never stall each other
   // the price is 32 multipliers and dividers; sharing one would break the one-cycle answer
   for (genvar u = 0; u < UNIT_COUNT; u++)
   begin : g_unit
      // per-unit state: configured mode and the held answer
      arith_op_t mode_ff;
      arith_op_t nxt_mode;
      unit_status_t status_ff;
      unit_status_t nxt_status;

      // operands and the wide values that overflow is judged on
      logic signed [DATA_W-1:0] op_a;
      logic signed [DATA_W-1:0] op_b;
      logic signed [DATA_W:0] sum_wide;
      logic signed [DATA_W:0] diff_wide;
      logic signed [PROD_W-1:0] prod_wide;
      logic signed [DATA_W-1:0] quot;
      logic div_bad;
      // range verdicts of each operation before selection
      logic sum_fits;
      logic diff_fits;
      logic prod_fits;
      // chosen value and its verdict for the current mode
      logic signed [DATA_W-1:0] candidate;
      logic candidate_ovf;

      // operand words taken as they stand; the feeding logic runs on this clock
      assign op_a = operand_i[u].first;
      assign op_b = operand_i[u].second;

      // mode register: stays at addition until software-side logic writes it
      // a write takes effect at the next edge; the edge that takes it still uses the old mode
      always_comb
      begin
         nxt_mode = mode_ff;
         if (mode_we_i[u])
         begin
            nxt_mode = mode_i[u];
         end
      end

      // mode flop: reset returns the unit to add mode
      always_ff @(posedge clk_sys_i or negedge reset_n_i)
      begin
         if (!reset_n_i)
         begin
            mode_ff <= MODE_RESET;
         end
         else
         begin
            mode_ff <= nxt_mode;
         end
      end

      // wide add and subtract keep the true sum so overflow is exact
      always_comb
      begin
         sum_wide = {op_a[DATA_W-1], op_a} + {op_b[DATA_W-1], op_b};
         diff_wide = {op_a[DATA_W-1], op_a} - {op_b[DATA_W-1], op_b};
         // a 33-bit signed value fits 32 bits when its top two bits agree
         sum_fits = (sum_wide[DATA_W] == sum_wide[DATA_W-1]);
         diff_fits = (diff_wide[DATA_W] == diff_wide[DATA_W-1]);
      end

      // full 64-bit product, judged before narrowing
      always_comb
      begin
         prod_wide = PROD_W'(op_a) * PROD_W'(op_b);
      end

      // the product fits when bits 63 down to 31 are all copies of the sign;
      // the low word alone would look plausible, so it is never used unjudged
      always_comb
      begin
         prod_fits = (&prod_wide[PROD_W-1:DATA_W-1]) || !(|prod_wide[PROD_W-1:DATA_W-1]);
      end

      // divide: zero divisor and min / -1 both fall outside the range
      always_comb
      begin
         div_bad = (op_b == VALUE_ZERO) || (op_a == VALUE_MIN && op_b == VALUE_MINUS_ONE);
         // guarded divisor avoids an undefined divide in the bad cases
         if (div_bad)
         begin
            quot = VALUE_ZERO;
         end
         else
         begin
            // both operands signed, so every sign mix rounds toward zero
            quot = op_a / op_b; // signed divide truncates toward zero
         end
      end

      // operation select and overflow verdict
      always_comb
      begin
         candidate = VALUE_ZERO;
         candidate_ovf = 1'b0;
         case (mode_ff)
            OP_ADD:
            begin
               // plain sum, judged on its 33-bit form
               candidate = sum_wide[DATA_W-1:0];
               candidate_ovf = !sum_fits;
            end
            OP_SUB:
            begin
               // first operand minus second
               candidate = diff_wide[DATA_W-1:0];
               candidate_ovf = !diff_fits;
            end
            OP_MUL:
            begin
               // low word is only passed on when the full product fits
               candidate = prod_wide[DATA_W-1:0];
               candidate_ovf = !prod_fits;
            end
            OP_DIV:
            begin
               // quotient, or a held result on a zero divisor or min / -1
               candidate = quot;
               candidate_ovf = div_bad;
            end
            default:
            begin
               // unreachable with four codes in two bits; fail safe by holding
               candidate = VALUE_ZERO;
               candidate_ovf = 1'b1;
            end
         endcase
      end

      // result held on overflow; zero flag follows the value actually presented
      always_comb
      begin
         nxt_status = status_ff;
         // a clear in the same cycle as an evaluation wins
         if (sync_clear_i)
         begin
            nxt_status = STATUS_RESET;
         end
         else
         begin
            // no enable: a fresh verdict every cycle
            nxt_status.overflow = candidate_ovf;
            // the result only moves on a good verdict
            if (!candidate_ovf)
            begin
               nxt_status.result = candidate;
            end
            // zero is judged on what will be presented, held or new
            nxt_status.zero = (nxt_status.result == VALUE_ZERO);
         end
      end

      // result and both flags move on the same edge
      // asynchronous reset presents zero before the first evaluation
      always_ff @(posedge clk_sys_i or negedge reset_n_i)
      begin
         if (!reset_n_i)
         begin
            status_ff <= STATUS_RESET;
         end
         else
         begin
            status_ff <= nxt_status;
         end
      end

      // outputs straight from the flops, so downstream logic sees no glitches
      assign result_output_o[u] = status_ff.result;
      // both flags change on the same edge as the result they describe
      assign overflow_flag_o[u] = status_ff.overflow;
      assign zero_flag_o[u] = status_ff.zero;
      // mode readback for whoever configures the unit
      assign mode_o[u] = mode_ff;
   end

endmodule

// ===== verification/arith_props.sv
/* checker on lane 0 of the arithmetic bank.
   assumes the bind below and a single clock. */
`timescale 1ns/1ps
module arith_props
   import arith_unit_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic sync_clear_i,
   input wire logic [UNIT_COUNT-1:0] mode_we_i,
   input wire arith_op_t mode_i [UNIT_COUNT],
   input wire operand_pair_t operand_i [UNIT_COUNT],
   input wire logic [DATA_W-1:0] result_output_o [UNIT_COUNT],
   input wire logic [UNIT_COUNT-1:0] overflow_flag_o,
   input wire logic [UNIT_COUNT-1:0] zero_flag_o,
   input wire arith_op_t mode_o [UNIT_COUNT]
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   // lane 0 only, since all lanes share one body
   wire logic signed [DATA_W-1:0] a = operand_i[0].first;
   wire logic signed [DATA_W-1:0] b = operand_i[0].second;
   wire logic signed [DATA_W:0] s = a + b;
   wire logic signed [PROD_W-1:0] p = a * b;
   wire logic [DATA_W-1:0] sl = s[DATA_W-1:0];
   wire logic [DATA_W-1:0] q = a / b;
   wire logic [DATA_W-1:0] r = result_output_o[0];
   wire logic sf = s[DATA_W] == s[DATA_W-1];
   wire logic pf = p == $signed(p[DATA_W-1:0]);
   wire logic signed [DATA_W:0] d = a - b;
   wire logic [DATA_W-1:0] dl = d[DATA_W-1:0];
   wire logic df = d[DATA_W] == d[DATA_W-1];
   wire logic [DATA_W-1:0] pl = p[DATA_W-1:0];
   wire logic ov = overflow_flag_o[0];
   wire logic go = !sync_clear_i;
   wire arith_op_t m = mode_o[0];
   a_add_in_range: assert property (go && m == OP_ADD && sf |=> r == $past(sl) && !ov)
      else $error("add result wrong");
   a_add_overflow_holds: assert property (go && m == OP_ADD && !sf |=> ov && $stable(r))
      else $error("add overflow not held");
   a_sub_in_range: assert property (go && m == OP_SUB && df |=> r == $past(dl) && !ov)
      else $error("sub result wrong");
   a_sub_overflow_holds: assert property (go && m == OP_SUB && !df |=> ov && $stable(r))
      else $error("sub overflow not held");
   a_mul_in_range: assert property (go && m == OP_MUL && pf |=> r == $past(pl) && !ov)
      else $error("product result wrong");
   a_mul_wide_product: assert property (go && m == OP_MUL && !pf |=> ov && $stable(r))
      else $error("product overflow missed");
   a_div_truncates: assert property (go && m == OP_DIV && b != 0 && !(a == VALUE_MIN && b == VALUE_MINUS_ONE)
      |=> r == $past(q) && !ov)
      else $error("quotient wrong");
   a_div_zero_holds: assert property (go && m == OP_DIV && b == 0 |=> ov && $stable(r))
      else $error("zero divisor not held");
   a_zero_tracks_result: assert property (zero_flag_o[0] == (r == 0))
      else $error("zero flag wrong");
   a_clear_zeroes_all: assert property (sync_clear_i |=> r == 0 && !ov && zero_flag_o[0])
      else $error("clear missed");
   a_mode_write_lands: assert property (mode_we_i[0] |=> m == $past(mode_i[0]))
      else $error("mode write lost");
   c_mul_over: cover property (go && m == OP_MUL && !pf);
   c_div_zero: cover property (m == OP_DIV && b == 0);
   c_clear: cover property (sync_clear_i);
   c_add_over: cover property (go && m == OP_ADD && !sf);
endmodule

bind arithmetic_unit arith_props arith_props_inst (.clk_sys_i, .reset_n_i, .sync_clear_i, .mode_we_i, .mode_i,
   .operand_i, .result_output_o, .overflow_flag_o, .zero_flag_o, .mode_o);

// ===== verification/operand_feed.sv
/* far side model: another block's output words feeding one operand pair.
   assumes the words are already settled on the system clock. */
`timescale 1ns/1ps
module operand_feed
   import arith_unit_pkg::*;
(
   input wire logic [DATA_W-1:0] first_i,
   input wire logic [DATA_W-1:0] second_i,
   output operand_pair_t pair_o
);
   // two full words handed on whole, first on top
   assign pair_o = '{first: first_i, second: second_i};
endmodule

// ===== verification/tb_top.sv
/* bench: lane 0 through every mode, boundaries and overflows.
   assumes the checker is bound and operand_feed feeds all lanes. */
`timescale 1ns/1ps
module tb_top
   import arith_unit_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic clr = 1'b0;
   logic [UNIT_COUNT-1:0] we = '0;
   arith_op_t md [UNIT_COUNT] = '{default: OP_ADD};
   logic signed [DATA_W-1:0] fa = '0;
   logic signed [DATA_W-1:0] fb = '0;
   logic signed [DATA_W-1:0] last = '0;
   operand_pair_t pr;
   operand_pair_t ops [UNIT_COUNT];
   logic [DATA_W-1:0] res [UNIT_COUNT];
   logic [UNIT_COUNT-1:0] ovf;
   logic [UNIT_COUNT-1:0] zf;
   arith_op_t mo [UNIT_COUNT];
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   // one feed for all lanes; only lane 0 leaves add mode
   always_comb
   begin
      for (int u = 0; u < UNIT_COUNT; u++)
      begin
         ops[u] = pr;
      end
   end
   operand_feed operand_feed_inst (.first_i(fa), .second_i(fb), .pair_o(pr));
   arithmetic_unit arithmetic_unit_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sync_clear_i(clr),
      .mode_we_i(we), .mode_i(md), .operand_i(ops), .result_output_o(res), .overflow_flag_o(ovf),
      .zero_flag_o(zf), .mode_o(mo));
   task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // on overflow the held value stays the expectation
   task automatic apply(input logic signed [DATA_W-1:0] a, b, v, input logic ov);
      if (!ov)
      begin
         last = v;
      end
      fa = a;
      fb = b;
      @(posedge clk_sys_i);
      #1;
      chk("result", res[0], last);
      chk("overflow", ovf[0], ov);
      chk("zero", zf[0], last == 0);
   endtask
   task automatic set_mode(input arith_op_t op);
      md[0] = op;
      we[0] = 1'b1;
      @(posedge clk_sys_i);
      #1;
      we[0] = 1'b0;
      chk("mode", mo[0], op);
   endtask
   task automatic t_reset();
      repeat (10) @(posedge clk_sys_i);
      #1;
      reset_n_i = 1'b1;
      chk("reset result", res[0], '0);
      chk("reset mode", mo[0], OP_ADD);
   endtask
   task automatic t_add();
      apply(42, 1000, 1042, 1'b0);
      apply(32'h7FFF_FFFF, 1, 0, 1'b1);
      apply(-2048, 1000, -1048, 1'b0);
   endtask
   task automatic t_sub();
      set_mode(OP_SUB);
      apply(1134, 42, 1092, 1'b0);
      apply(VALUE_MIN, 3, 0, 1'b1);
      apply(-4096, -1000, -3096, 1'b0);
   endtask
   task automatic t_mul();
      set_mode(OP_MUL);
      apply(12, 12, 144, 1'b0);
      apply(1000042, 2401, 0, 1'b1);
      apply(-65536, 32768, VALUE_MIN, 1'b0);
      apply(65536, 32768, 0, 1'b1);
   endtask
   task automatic t_div();
      set_mode(OP_DIV);
      apply(1024, 35, 29, 1'b0);
      apply(1024, 0, 0, 1'b1);
      apply(-1000, 10, -100, 1'b0);
      apply(1000, -10, -100, 1'b0);
      apply(VALUE_MIN, -1, 0, 1'b1);
      apply(10, 100, 0, 1'b0);
   endtask
   task automatic t_clear();
      apply(-1000, -10, 100, 1'b0);
      clr = 1'b1;
      @(posedge clk_sys_i);
      #1;
      clr = 1'b0;
      chk("clear result", res[0], '0);
      chk("clear mode", mo[0], OP_DIV);
      @(posedge clk_sys_i);
      #1;
      chk("lane 1 sum", res[1], -1010);
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && total_checks > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // a hung run is cut here and judged failed
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   initial
   begin
      t_reset();
      t_add();
      t_sub();
      t_mul();
      t_div();
      t_clear();
      report_and_stop();
   end
endmodule
